// ===== core/fp_status_cfg.svh
// Bit positions, reset values and codes of the floating-point status word
`ifndef FP_STATUS_CFG_SVH
`define FP_STATUS_CFG_SVH
`define MODE_HI        31
`define MODE_LO        28
`define AU_BIT         22
`define TRAP_EN_HI     27
`define TRAP_EN_LO     23
`define RSVD_HI        21
`define RSVD_LO        17
`define RSVD_BIT       12
`define TRAP_TYPE_HI   16
`define TRAP_TYPE_LO   14
`define QUEUE_BUSY_BIT 13
`define COND_HI        11
`define COND_LO        10
`define ACCRUED_HI     9
`define ACCRUED_LO     5
`define CURRENT_HI     4
`define CURRENT_LO     0
`define EXC_RESET      5'h00
`define COND_RESET     2'h0
`define TT_NONE        3'h0
`define TT_ARITH       3'h1
`define TT_INCOMPLETE  3'h2
`define TT_MISSING     3'h3
`define TT_SEQUENCE    3'h4
`define COND_EQUAL     2'h0
`define COND_LESS      2'h1
`define COND_GREATER   2'h2
`define COND_UNORDERED 2'h3
`define QUEUE_DEPTH    2
`endif

// ===== core/fp_status_pkg.sv
// Types shared by the floating-point status logic
package fp_status_pkg;
  typedef enum logic [1:0] {
    CMP_EQUAL,
    CMP_LESS,
    CMP_GREATER
  } cmp_rel_t;
  typedef enum logic [1:0] {
    END_NORMAL,
    END_INCOMPLETE,
    END_MISSING
  } op_end_t;
endpackage : fp_status_pkg

// ===== core/fp_queue_mem.sv
// Pending-operation queue: address and instruction pairs, registered read
`include "fp_status_cfg.svh"
module fp_queue_mem #(
  parameter int DEPTH = `QUEUE_DEPTH
) (
  input  wire logic              CORE_CLK,
  input  wire logic              ARST_N,
  input  wire logic              push,
  input  wire logic [63:0]       push_data,
  input  wire logic              pop,
  input  wire logic              flush,
  output logic                   empty,
  output logic                   full,
  output logic [63:0]            head_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [63:0] mem [DEPTH];
  logic [AW:0] count;
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] wr_ptr;
  wire do_pop  = pop && !empty;
  wire do_push = push && !full;
  wire [AW-1:0] rd_next = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
  wire [AW-1:0] wr_next = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
  assign empty = (count == '0);
  assign full  = (count == (AW+1)'(DEPTH));
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      count  <= '0;
      rd_ptr <= '0;
      wr_ptr <= '0;
    end else if (flush) begin
      count  <= '0;
      rd_ptr <= '0;
      wr_ptr <= '0;
    end else begin
      if (do_push) wr_ptr <= wr_next;
      if (do_pop) rd_ptr <= rd_next;
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
  always_ff @(posedge CORE_CLK) begin
    if (do_push) mem[wr_ptr] <= push_data;
  end
  // Registered head; shows the entry being taken by a pop
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) head_data <= 64'h0;
    else if (do_pop) head_data <= mem[rd_ptr];
  end
endmodule : fp_queue_mem

// ===== core/fp_cond_eval.sv
// Compare result coding and conditional-branch decision
`include "fp_status_cfg.svh"
module fp_cond_eval (
  input  wire logic [1:0]        rel,
  input  wire logic              src1_nan,
  input  wire logic              src2_nan,
  input  wire logic [1:0]        cond,
  input  wire logic [3:0]        br_mask,
  output logic [1:0]             cmp_code,
  output logic                   br_taken
);
  // Any NaN source forces unordered
  wire unordered = src1_nan || src2_nan;
  assign cmp_code = unordered ? `COND_UNORDERED :
                    (rel == fp_status_pkg::CMP_LESS)    ? `COND_LESS :
                    (rel == fp_status_pkg::CMP_GREATER) ? `COND_GREATER : `COND_EQUAL;
  // One mask bit per code value
  assign br_taken = br_mask[cond];
endmodule : fp_cond_eval

// ===== core/fp_status_exception_unit.sv
// Floating-point status word, exception decision and pending queue
// Notes on behaviour
// - trap type in bits 16:14 after trap
// - trap type readable, load leaves it
// - sequence error on fetch while halted
// - bit 13 shows queue occupancy
// - load ignores bit; queue stores drain
// - compares update codes; trapping ones only if signaling
// - codes equal/less/greater/unordered; branch uses
// - any NaN operand gives unordered
// - accrued flags at bits 9:5
// - mask and current decide trap/accrue
// - accrued field stored and loaded
// - current flags bits 4:0, cleared if absent
// - current field stored and loaded
// - current undefined after incomplete/missing fault
// - invalid flag for improper operand
// - overflow flag when result too large
// - underflow needs inexact and tiny
// - divide-by-zero for nonzero over zero
// - inexact when rounded differs
// - hardware never clears accrued or type
// - queue head holds faulting op
// - in-flight ops never exceed entries
// - trap enables at bits 27:23
// - reserved bits read zero
`include "fp_status_cfg.svh"
module fp_status_exception_unit #(
  parameter int QUEUE_DEPTH = `QUEUE_DEPTH
) (
  input  wire logic              CORE_CLK,
  input  wire logic              ARST_N,
  input  wire logic              LOAD_FP_STATUS,
  input  wire logic [31:0]       LOAD_DATA,
  input  wire logic              STORE_FP_STATUS,
  output logic [31:0]            STORE_DATA,
  input  wire logic              STORE_FP_QUEUE_ENTRY,
  output logic [63:0]            QUEUE_ENTRY_DATA,
  input  wire logic              ISSUE,
  input  wire logic [31:0]       ISSUE_ADDR,
  input  wire logic [31:0]       ISSUE_INSTR,
  output logic                   ISSUE_READY,
  input  wire logic              FETCH_FP_OP,
  input  wire logic              OP_DONE,
  input  wire logic [1:0]        OP_END,
  input  wire logic              OP_IS_COMPARE,
  input  wire logic              OP_IS_SIGNALING,
  input  wire logic              OP_IS_DIVIDE,
  input  wire logic              OPERAND_IMPROPER,
  input  wire logic              RESULT_TOO_LARGE,
  input  wire logic              RESULT_TINY,
  input  wire logic              RESULT_ROUNDED,
  input  wire logic              DIVIDEND_NONZERO,
  input  wire logic              DIVISOR_ZERO,
  input  wire logic [1:0]        CMP_REL,
  input  wire logic              SRC1_NAN,
  input  wire logic              SRC2_NAN,
  input  wire logic [3:0]        BRANCH_MASK,
  output logic                   BRANCH_TAKEN,
  output logic                   WRITE_RESULT,
  output logic                   FLOAT_TRAP_EVENT,
  output logic                   FPU_HALTED_PENDING
);
  logic [4:0]  trap_en;
  logic        abrupt_uf;
  logic [3:0]  mode_bits;
  logic [2:0]  trap_type;
  logic [1:0]  cond;
  logic [4:0]  accrued;
  logic [4:0]  current;
  logic        halted;
  logic        trap_pulse;
  logic        write_pulse;
  logic        q_empty;
  logic        q_full;
  logic [1:0]  cmp_code;

  wire exc_nv = OPERAND_IMPROPER;
  wire exc_of = RESULT_TOO_LARGE;
  wire exc_nx = RESULT_ROUNDED;
  wire exc_uf = RESULT_TINY && RESULT_ROUNDED;
  wire exc_dz = OP_IS_DIVIDE && DIVISOR_ZERO && DIVIDEND_NONZERO;
  wire [4:0] next_current = {exc_nv, exc_of, exc_uf, exc_dz, exc_nx};
  wire normal_end = (OP_END == fp_status_pkg::END_NORMAL);
  wire [4:0] masked = next_current & trap_en;
  wire arith_trap = OP_DONE && normal_end && (masked != 5'h00);
  wire fault_trap = OP_DONE && !normal_end;
  wire seq_err = FETCH_FP_OP && halted;
  wire any_trap = arith_trap || fault_trap || seq_err;
  wire q_pop = STORE_FP_QUEUE_ENTRY;
  // no issue past queue capacity or while halted
  assign ISSUE_READY = !q_full && !halted;
  wire q_push = ISSUE && ISSUE_READY;
  // Completed op leaves queue unless it traps (then it stays at head) or the unit is halted
  wire retire = OP_DONE && !arith_trap && !fault_trap && !halted;

  wire [2:0] next_trap_type =
    seq_err    ? `TT_SEQUENCE :
    arith_trap ? `TT_ARITH :
    (OP_END == fp_status_pkg::END_MISSING) ? `TT_MISSING : `TT_INCOMPLETE;

  wire [31:0] status_word = {
    mode_bits, trap_en, abrupt_uf, 5'h00, trap_type, !q_empty, 1'b0,
    cond, accrued, current};

  fp_queue_mem #(
    .DEPTH(QUEUE_DEPTH)
  ) u_queue (
    .CORE_CLK  (CORE_CLK),
    .ARST_N    (ARST_N),
    .push      (q_push),
    .push_data ({ISSUE_ADDR, ISSUE_INSTR}),
    .pop       (q_pop || retire),
    .flush     (1'b0),
    .empty     (q_empty),
    .full      (q_full),
    .head_data (QUEUE_ENTRY_DATA)
  );

  fp_cond_eval u_cond (
    .rel      (CMP_REL),
    .src1_nan (SRC1_NAN),
    .src2_nan (SRC2_NAN),
    .cond     (cond),
    .br_mask  (BRANCH_MASK),
    .cmp_code (cmp_code),
    .br_taken (BRANCH_TAKEN)
  );

  // Software-owned mode fields and enables
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      trap_en   <= `EXC_RESET;
      abrupt_uf <= 1'b0;
      mode_bits <= 4'h0;
    end else if (LOAD_FP_STATUS) begin
      trap_en   <= LOAD_DATA[`TRAP_EN_HI:`TRAP_EN_LO];
      abrupt_uf <= LOAD_DATA[`AU_BIT];
      mode_bits <= LOAD_DATA[`MODE_HI:`MODE_LO];
    end
  end

  // type captured on trap, held otherwise
  // only a trap rewrites it; load never touches it
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) trap_type <= `TT_NONE;
    else if (any_trap) trap_type <= next_trap_type;
  end

  // Halted from trap until a queue store finds the queue already empty
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) halted <= 1'b0;
    else if (any_trap) halted <= 1'b1;
    // a queue store with the queue already empty releases the halt
    else if (q_pop && q_empty) halted <= 1'b0;
  end

  // compares write codes; a trapping compare only if signaling
  wire cmp_update = OP_DONE && normal_end && OP_IS_COMPARE &&
                    (!arith_trap || OP_IS_SIGNALING);
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) cond <= `COND_RESET;
    else if (cmp_update) cond <= cmp_code;
    else if (LOAD_FP_STATUS) cond <= LOAD_DATA[`COND_HI:`COND_LO];
  end

  // left as is after a fault trap
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) current <= `EXC_RESET;
    else if (OP_DONE && normal_end) current <= next_current;
    else if (LOAD_FP_STATUS) current <= LOAD_DATA[`CURRENT_HI:`CURRENT_LO];
  end

  // load writes, store reads
  // A same-cycle load is ORed with the new flags so no event is lost
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) accrued <= `EXC_RESET;
    else if (OP_DONE && normal_end && !arith_trap) begin
      if (LOAD_FP_STATUS) accrued <= LOAD_DATA[`ACCRUED_HI:`ACCRUED_LO] | next_current;
      else accrued <= accrued | next_current;
    end else if (LOAD_FP_STATUS) accrued <= LOAD_DATA[`ACCRUED_HI:`ACCRUED_LO];
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      trap_pulse  <= 1'b0;
      write_pulse <= 1'b0;
      STORE_DATA  <= 32'h0;
    end else begin
      trap_pulse  <= any_trap;
      write_pulse <= OP_DONE && normal_end && !arith_trap && !halted;
      if (STORE_FP_STATUS) STORE_DATA <= status_word;
    end
  end

  assign FLOAT_TRAP_EVENT   = trap_pulse;
  assign WRITE_RESULT       = write_pulse;
  assign FPU_HALTED_PENDING = halted;
endmodule : fp_status_exception_unit

// ===== dv/fp_status_chk.sv
// Port-level assertions for the floating-point status unit
module fp_status_chk (
  input wire logic        CORE_CLK,
  input wire logic        ARST_N,
  input wire logic        LOAD_FP_STATUS,
  input wire logic [31:0] LOAD_DATA,
  input wire logic        STORE_FP_STATUS,
  input wire logic [31:0] STORE_DATA,
  input wire logic        ISSUE_READY,
  input wire logic        OP_DONE,
  input wire logic [1:0]  OP_END,
  input wire logic        WRITE_RESULT,
  input wire logic        FLOAT_TRAP_EVENT,
  input wire logic        FPU_HALTED_PENDING
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  // Fields a load really stores
  wire [31:0] kept = LOAD_DATA & 32'hFFC0_0FFF;
  sequence s_fault;
    OP_DONE && !FPU_HALTED_PENDING && OP_END != 2'h0;
  endsequence
  sequence s_load_store;
    LOAD_FP_STATUS && !OP_DONE ##1 STORE_FP_STATUS && !LOAD_FP_STATUS && !OP_DONE;
  endsequence
  a_halt_blocks_issue: assert property (FPU_HALTED_PENDING |-> !ISSUE_READY)
    else $error("issue accepted while halted");
  a_trap_halts: assert property (FLOAT_TRAP_EVENT |-> FPU_HALTED_PENDING)
    else $error("trap without halt");
  a_halt_cause: assert property ($rose(FPU_HALTED_PENDING) |-> FLOAT_TRAP_EVENT)
    else $error("halt without trap");
  a_trap_not_write: assert property (!(FLOAT_TRAP_EVENT && WRITE_RESULT))
    else $error("trap and result write together");
  a_write_cause: assert property (WRITE_RESULT |-> $past(OP_DONE) && $past(OP_END) == 2'h0)
    else $error("result write without normal completion");
  a_fault_traps: assert property (s_fault |=> FLOAT_TRAP_EVENT ##0 !WRITE_RESULT)
    else $error("fault completion did not trap");
  a_reserved_zero: assert property (STORE_DATA[21:17] == 5'h00 && !STORE_DATA[12])
    else $error("reserved bits not zero");
  a_store_stands: assert property (!STORE_FP_STATUS |=> $stable(STORE_DATA))
    else $error("stored status changed without store");
  a_load_readback: assert property (s_load_store |=> (STORE_DATA & 32'hFFC0_0FFF) == $past(kept, 2))
    else $error("loaded fields not read back");
endmodule : fp_status_chk

bind fp_status_exception_unit fp_status_chk chk (
  .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .LOAD_FP_STATUS(LOAD_FP_STATUS),
  .LOAD_DATA(LOAD_DATA), .STORE_FP_STATUS(STORE_FP_STATUS), .STORE_DATA(STORE_DATA),
  .ISSUE_READY(ISSUE_READY), .OP_DONE(OP_DONE), .OP_END(OP_END),
  .WRITE_RESULT(WRITE_RESULT), .FLOAT_TRAP_EVENT(FLOAT_TRAP_EVENT),
  .FPU_HALTED_PENDING(FPU_HALTED_PENDING)
);

// ===== dv/iu_issue_model.sv
// Integer-unit side: issues operations into the unit on request
module iu_issue_model (
  input  wire logic        clk,
  input  wire logic        req,
  input  wire logic        pushy,
  input  wire logic        ready,
  output logic             issue,
  output logic [31:0]      addr,
  output logic [31:0]      instr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic r, p;
  initial begin
    issue = 0;
    addr = 0;
    instr = 0;
  end
  always @(posedge clk) begin
    r = req;
    p = pushy;
    #10;
    // Pushy mode ignores ready to provoke a refusal
    if (r && (ready || p)) begin
      issue = 1;
      addr = $urandom;
      instr = $urandom;
    end else begin
      issue = 0;
      addr = ~addr;
      instr = ~instr;
    end
  end
endmodule : iu_issue_model

// ===== dv/fp_status_exception_unit_test.sv
// Self-checking bench for the floating-point status unit
module fp_status_exception_unit_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, arst_n = 0, ld = 0, st = 0, sq = 0, req = 0, pushy = 0;
  logic        fetch = 0, done = 0, n1 = 0, n2 = 0, sd = 0, qd = 0;
  logic [1:0]  oend = 0, rel = 0;
  logic [3:0]  bm = 0;
  logic [8:0]  f = 0;
  logic [31:0] ldat = 0, s;
  wire  [31:0] sdat, ia, ii;
  wire  [63:0] qdat;
  wire         iss, rdy, bt, wr, ev, hlt;
  logic [63:0] pend[$];
  logic [65:0] exp_q[$];
  int          bad_count = 0, total_checks = 0;
  initial forever #50 clk = ~clk;
  fp_status_exception_unit DUT (
    .CORE_CLK(clk), .ARST_N(arst_n), .LOAD_FP_STATUS(ld), .LOAD_DATA(ldat),
    .STORE_FP_STATUS(st), .STORE_DATA(sdat), .STORE_FP_QUEUE_ENTRY(sq),
    .QUEUE_ENTRY_DATA(qdat), .ISSUE(iss), .ISSUE_ADDR(ia), .ISSUE_INSTR(ii),
    .ISSUE_READY(rdy), .FETCH_FP_OP(fetch), .OP_DONE(done), .OP_END(oend),
    .OP_IS_COMPARE(f[8]), .OP_IS_SIGNALING(f[7]), .OP_IS_DIVIDE(f[6]),
    .OPERAND_IMPROPER(f[5]), .RESULT_TOO_LARGE(f[4]), .RESULT_TINY(f[3]),
    .RESULT_ROUNDED(f[2]), .DIVIDEND_NONZERO(f[1]), .DIVISOR_ZERO(f[0]),
    .CMP_REL(rel), .SRC1_NAN(n1), .SRC2_NAN(n2), .BRANCH_MASK(bm),
    .BRANCH_TAKEN(bt), .WRITE_RESULT(wr), .FLOAT_TRAP_EVENT(ev),
    .FPU_HALTED_PENDING(hlt)
  );
  iu_issue_model iu (.clk(clk), .req(req), .pushy(pushy), .ready(rdy), .issue(iss),
    .addr(ia), .instr(ii));
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #10;
  endtask : tick
  task automatic chk(input string nm, input logic [65:0] e, input logic [65:0] g);
    total_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : chk
  // Passed by reference so the pulse reaches the design while the task runs
  task automatic strobe(ref logic sig);
    sig = 1;
    tick;
    sig = 0;
    tick;
  endtask : strobe
  task automatic store(input logic [31:0] e);
    exp_q.push_back({2'h1, 32'h0, e});
    strobe(st);
  endtask : store
  task automatic qstore(input logic [63:0] e);
    exp_q.push_back({2'h2, e});
    strobe(sq);
  endtask : qstore
  task automatic load(input logic [31:0] w);
    ld = 1;
    ldat = w;
    tick;
    ld = 0;
  endtask : load
  task automatic complete(input logic [1:0] e, input logic [8:0] fl);
    logic [4:0] c;
    logic [1:0] cc;
    c = {fl[5], fl[4], fl[3] & fl[2], fl[6] & fl[1] & fl[0], fl[2]};
    f = fl;
    oend = e;
    rel = 2'($urandom_range(2));
    n1 = ($urandom_range(3) == 0);
    n2 = ($urandom_range(3) == 0);
    bm = 4'($urandom);
    cc = (n1 | n2) ? 2'h3 : rel;
    done = 1;
    if (e != 2'h0 || (c & s[27:23]) != 5'h00) begin
      s[16:14] = (e == 2'h0) ? 3'h1 : {1'b0, e} + 3'h1;
      s[13] = 1'b1;
      if (e == 2'h0) s[4:0] = c;
      if (e == 2'h0 && fl[8] && fl[7]) s[11:10] = cc;
      exp_q.push_back({2'h3, 64'h2});
    end else begin
      s[4:0] = c;
      s[9:5] = s[9:5] | c;
      if (fl[8]) s[11:10] = cc;
      exp_q.push_back({2'h3, 64'h1});
      void'(pend.pop_front());
    end
    tick;
    done = 0;
    tick;
    chk("branch", bm[s[11:10]], bt);
  endtask : complete
  task automatic drain;
    logic [63:0] last;
    while (pend.size() != 0) begin
      last = pend.pop_front();
      qstore(last);
      s[13] = (pend.size() != 0);
      store(s);
    end
    qstore(last);
    chk("halted", 1'b0, hlt);
    chk("ready", 1'b1, rdy);
  endtask : drain
  task automatic finish_test;
    if (exp_q.size() != 0) bad_count++;
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    sd <= st;
    qd <= sq;
    if (iss === 1'b1 && !pushy) pend.push_back({ia, ii});
  end
  // Oldest note is matched against whatever result shows up
  always @(negedge clk) begin
    logic [65:0] want;
    if (sd || qd || ev === 1'b1 || wr === 1'b1) begin
      want = (exp_q.size() != 0) ? exp_q.pop_front() : '1;
      if (sd) chk("status", want, {2'h1, 32'h0, sdat});
      else if (qd) chk("entry", want, {2'h2, qdat});
      else chk("pulse", want, {2'h3, 62'h0, ev, wr});
    end
  end
  initial begin
    #400000;
    bad_count++;
    finish_test;
  end
  initial begin
    logic [31:0] w;
    w = $urandom(32'hD479);
    tick(5);
    arst_n = 1;
    tick;
    s = 32'h0;
    store(s);
    chk("ready", 1'b1, rdy);
    w = $urandom;
    s = w & 32'hFFC0_0FFF;
    load(w);
    store(s);
    s[27:23] = 5'h00;
    load(s);
    repeat (12) begin
      tick;
      strobe(req);
      complete(2'h0, 9'($urandom));
      store(s);
    end
    s[27:23] = 5'h01 << $urandom_range(4);
    load(s);
    strobe(req);
    strobe(req);
    chk("ready", 1'b0, rdy);
    pushy = 1;
    strobe(req);
    pushy = 0;
    complete(2'h0, 9'h1FF);
    store(s);
    s[16:14] = 3'h4;
    exp_q.push_back({2'h3, 64'h2});
    strobe(fetch);
    w = $urandom;
    s = (w & 32'hFFC0_0FFF) | (s & 32'h0001_E000);
    load(w);
    store(s);
    drain;
    for (int e = 1; e < 3; e++) begin
      strobe(req);
      complete(2'(e), 9'($urandom));
      store(s);
      drain;
    end
    finish_test;
  end
endmodule : fp_status_exception_unit_test
